// ==== logic/dfac_params.svh ====
// constants for the data flash access control block
`ifndef DFAC_PARAMS_SVH
`define DFAC_PARAMS_SVH

// register offsets (word index on the plain port)
`define DFAC_OFS_READ_EN0 4'h0
`define DFAC_OFS_READ_EN1 4'h1
`define DFAC_OFS_PE_EN0 4'h2
`define DFAC_OFS_PE_EN1 4'h3
`define DFAC_OFS_MODE_ENTRY 4'h4
`define DFAC_OFS_CLK_NOTIFY 4'h5
`define DFAC_OFS_CMD 4'h6
`define DFAC_OFS_STATUS 4'h7
`define DFAC_OFS_BLANK_CHECK 4'h8
`define DFAC_OFS_RD_ADDR 4'h9
`define DFAC_OFS_RD_DATA 4'ha

// key codes, arbitrary values
`define DFAC_ENABLE_KEY 8'h2d
`define DFAC_ENTRY_KEY 8'haa

// field positions
`define DFAC_KEY_LSB 8
`define DFAC_ENTRY_DF_BIT 7
`define DFAC_BC_SIZE_BIT 15

// command codes
`define DFAC_CMD_PROG2 8'h01

// geometry
`define DFAC_BLOCK_BYTES 32
`define DFAC_NUM_BLOCKS 1024
`define DFAC_GROUP_BLOCKS 64
`define DFAC_NUM_GROUPS 8
`define DFAC_ADDR_W 15

// timing: read takes three flash clock cycles; program busy time
`define DFAC_READ_CYCLES 3
`define DFAC_PE_BUSY_CYCLES 16

// reset values
`define DFAC_RESET_16 16'h0000

`endif

// ==== logic/dfac_pkg.sv ====
// types for the data flash access control block
`default_nettype none
package dfac_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dfac_bus_req_t;

    typedef struct packed {
        logic go;
        logic is_write;
        logic [14:0] addr;
        logic [15:0] wdata;
    } dfac_flash_req_t;

    typedef enum logic [1:0] {
        DFAC_IDLE = 2'b00,
        DFAC_READ = 2'b01,
        DFAC_PE = 2'b11
    } dfac_state_t;
endpackage
`default_nettype wire

// ==== logic/dfac_read_timer.sv ====
// counts the flash clock cycles of one data flash read
`timescale 1ns/10ps
`default_nettype none
`include "dfac_params.svh"
module dfac_read_timer #(
    parameter int CYCLES = `DFAC_READ_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // control
    input wire logic start_i,
    output logic done_o
);
    logic [3:0] count;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count <= 4'h0;
            done_o <= 1'b0;
        end else if (start_i) begin
            count <= 4'(CYCLES - 1);
            done_o <= 1'b0;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
            done_o <= (count == 4'h1);
        end else begin
            done_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== logic/dfac_top.sv ====
// data flash access control: enables, mode entry, read timing and program requests
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "dfac_params.svh"
module dfac_top #(
    parameter int ROM_REGIONS = 4,
    parameter int READ_CYCLES = `DFAC_READ_CYCLES,
    parameter int PE_CYCLES = `DFAC_PE_BUSY_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // flash array side
    input wire logic [15:0] flash_rdata_i,
    output dfac_pkg::dfac_flash_req_t flash_req_o,
    // mode outputs
    output logic [3:0] rom_pe_entry_o,
    output logic data_flash_pe_entry_o,
    output logic rom_fetch_allow_o,
    output logic pe_busy_o,
    output logic access_error_o
);
    dfac_pkg::dfac_bus_req_t bus;
    dfac_pkg::dfac_state_t state;
    logic [7:0] read_enable;
    logic [7:0] pe_enable;
    logic [7:0] mode_entry;
    logic [15:0] clock_notification;
    logic clock_noted;
    logic [15:0] blank_check;
    logic [14:0] rd_addr;
    logic [15:0] rd_data;
    logic [15:0] cmd_data;
    logic [7:0] pe_count;
    logic rd_done;
    logic rd_start;
    logic enable_key_ok;
    logic entry_key_ok;
    logic [7:0] entry_bits;
    logic [2:0] rd_group;
    logic [2:0] cmd_group;
    logic [3:0] rom_mask;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign enable_key_ok = bus.wdata[15:`DFAC_KEY_LSB] == `DFAC_ENABLE_KEY;
    assign entry_key_ok = bus.wdata[15:`DFAC_KEY_LSB] == `DFAC_ENTRY_KEY;
    assign rom_mask = 4'((5'h1 << ROM_REGIONS) - 5'h1);
    assign entry_bits = {bus.wdata[7], 3'h0, bus.wdata[3:0] & rom_mask};
    // block = addr/32, group = (block/64) mod 8, i.e. addr bits 13:11
    assign rd_group = rd_addr[13:11];
    // program is gated by the group of the address, never of the data
    assign cmd_group = rd_addr[13:11];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            read_enable <= 8'h00;
        end else if (bus.wr && bus.addr == `DFAC_OFS_READ_EN0 && enable_key_ok) begin
            read_enable <= bus.wdata[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pe_enable <= 8'h00;
        end else if (bus.wr && bus.addr == `DFAC_OFS_PE_EN0 && enable_key_ok) begin
            pe_enable <= bus.wdata[7:0];
        end
    end

    // keyed entry, at most one bit; clearing allowed with the key
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_entry <= 8'h00;
        end else if (bus.wr && bus.addr == `DFAC_OFS_MODE_ENTRY && entry_key_ok) begin
            if ($countones(entry_bits) <= 1) begin
                mode_entry <= entry_bits;
            end
        end
    end

    // clock notification; no program or erase until it is written
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            clock_notification <= `DFAC_RESET_16;
            clock_noted <= 1'b0;
        end else if (bus.wr && bus.addr == `DFAC_OFS_CLK_NOTIFY) begin
            clock_notification <= bus.wdata;
            clock_noted <= 1'b1;
        end
    end

    // blank check size bit 15, address in low bits
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            blank_check <= `DFAC_RESET_16;
        end else if (bus.wr && bus.addr == `DFAC_OFS_BLANK_CHECK) begin
            blank_check <= {bus.wdata[`DFAC_BC_SIZE_BIT], 4'h0, bus.wdata[10:0]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_addr <= 15'h0000;
        end else if (bus.wr && bus.addr == `DFAC_OFS_RD_ADDR) begin
            rd_addr <= bus.wdata[14:0];
        end
    end

    assign rd_start = bus.wr && bus.addr == `DFAC_OFS_RD_ADDR && state == dfac_pkg::DFAC_IDLE;

    dfac_read_timer #(
        .CYCLES(READ_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(rd_start),
        .done_o(rd_done)
    );

    // data word for the next two-byte program at the address register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cmd_data <= 16'h0000;
        end else if (bus.wr && bus.addr == `DFAC_OFS_RD_DATA) begin
            cmd_data <= bus.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= dfac_pkg::DFAC_IDLE;
            pe_count <= 8'h00;
            rd_data <= 16'h0000;
            access_error_o <= 1'b0;
            flash_req_o <= '0;
        end else begin
            flash_req_o.go <= 1'b0;
            // error clear first, so an error raised in the same cycle wins
            if (bus.wr && bus.addr == `DFAC_OFS_STATUS) begin
                access_error_o <= 1'b0;
            end
            case (state)
                dfac_pkg::DFAC_IDLE: begin
                    if (rd_start) begin
                        state <= dfac_pkg::DFAC_READ;
                    end else if (bus.wr && bus.addr == `DFAC_OFS_CMD &&
                                 bus.wdata[7:0] == `DFAC_CMD_PROG2) begin
                        // program gated by mode, enable and clock
                        if (mode_entry[`DFAC_ENTRY_DF_BIT] && pe_enable[cmd_group] &&
                            clock_noted) begin
                            state <= dfac_pkg::DFAC_PE;
                            pe_count <= 8'(PE_CYCLES);
                            flash_req_o <= '{go: 1'b1, is_write: 1'b1,
                                             addr: {rd_addr[14:1], 1'b0}, wdata: cmd_data};
                        end else begin
                            access_error_o <= 1'b1;
                        end
                    end
                end
                dfac_pkg::DFAC_READ: begin
                    if (rd_done) begin
                        state <= dfac_pkg::DFAC_IDLE;
                        // reads of disabled groups return zero
                        if (read_enable[rd_group]) begin
                            rd_data <= flash_rdata_i;
                        end else begin
                            rd_data <= 16'h0000;
                            access_error_o <= 1'b1;
                        end
                    end
                end
                dfac_pkg::DFAC_PE: begin
                    pe_count <= pe_count - 8'h1;
                    if (pe_count == 8'h1) begin
                        state <= dfac_pkg::DFAC_IDLE;
                    end
                end
                default: begin
                    state <= dfac_pkg::DFAC_IDLE;
                end
            endcase
        end
    end

    // rom fetch held open during data flash work
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rom_pe_entry_o <= 4'h0;
            data_flash_pe_entry_o <= 1'b0;
            rom_fetch_allow_o <= 1'b1;
            pe_busy_o <= 1'b0;
        end else begin
            rom_pe_entry_o <= mode_entry[3:0];
            data_flash_pe_entry_o <= mode_entry[`DFAC_ENTRY_DF_BIT];
            rom_fetch_allow_o <= mode_entry[3:0] == 4'h0;
            pe_busy_o <= state == dfac_pkg::DFAC_PE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= 16'h0000;
        end else if (bus.rd) begin
            case (bus.addr)
                `DFAC_OFS_READ_EN0: rdata_o <= {8'h00, read_enable};
                `DFAC_OFS_PE_EN0: rdata_o <= {8'h00, pe_enable};
                `DFAC_OFS_MODE_ENTRY: rdata_o <= {8'h00, mode_entry};
                `DFAC_OFS_CLK_NOTIFY: rdata_o <= clock_notification;
                `DFAC_OFS_CMD: rdata_o <= cmd_data;
                `DFAC_OFS_STATUS: rdata_o <= {13'h0000, access_error_o, state};
                `DFAC_OFS_BLANK_CHECK: rdata_o <= blank_check;
                `DFAC_OFS_RD_ADDR: rdata_o <= {1'b0, rd_addr};
                `DFAC_OFS_RD_DATA: rdata_o <= rd_data;
                default: rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // read finishes three cycles after start
    chk_read_three: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_start |-> ##3 rd_done)
        else $error("read did not finish in three cycles");

    chk_entry_onehot: assert property (@(posedge clk_i) disable iff (reset_i)
        $countones(mode_entry) <= 1)
        else $error("more than one entry bit set");

    // program only in data flash mode
    chk_prog_mode: assert property (@(posedge clk_i) disable iff (reset_i)
        flash_req_o.go |-> data_flash_pe_entry_o && clock_noted)
        else $error("program issued outside program mode");

    chk_key_guard: assert property (@(posedge clk_i) disable iff (reset_i)
        (bus.wr && bus.addr == `DFAC_OFS_READ_EN0 && !enable_key_ok)
        |=> $stable(read_enable))
        else $error("read enable changed on bad key");

    chk_read_gate: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == dfac_pkg::DFAC_READ && rd_done && !read_enable[rd_group])
        |=> rd_data == 16'h0000)
        else $error("read of disabled group returned data");

    // program steps: one request pulse, then the busy phase
    sequence s_prog_issue;
        flash_req_o.go && flash_req_o.is_write;
    endsequence

    sequence s_prog_busy;
        pe_busy_o [*8];
    endsequence

    // busy follows each request; needs PE_CYCLES of 8 or more
    chk_prog_busy: assert property (@(posedge clk_i) disable iff (reset_i)
        s_prog_issue |=> s_prog_busy)
        else $error("busy not held after program request");

    // request is a single cycle pulse
    chk_go_single: assert property (@(posedge clk_i) disable iff (reset_i)
        flash_req_o.go |=> !flash_req_o.go)
        else $error("program request longer than one cycle");

    // request only into an enabled group
    chk_prog_group: assert property (@(posedge clk_i) disable iff (reset_i)
        flash_req_o.go |-> pe_enable[flash_req_o.addr[13:11]])
        else $error("program issued into disabled group");

    // bad entry key leaves mode unchanged
    chk_entry_key: assert property (@(posedge clk_i) disable iff (reset_i)
        (bus.wr && bus.addr == `DFAC_OFS_MODE_ENTRY && !entry_key_ok)
        |=> $stable(mode_entry))
        else $error("mode entry changed on bad key");

    // rom fetch open in data flash mode
    chk_fetch_in_df: assert property (@(posedge clk_i) disable iff (reset_i)
        data_flash_pe_entry_o |-> rom_fetch_allow_o)
        else $error("rom fetch blocked in data flash mode");
endmodule
`default_nettype wire

// ==== testbench/dfac_bench.sv ====
// self-checking bench for the data flash access control block
`timescale 1ns/10ps
`default_nettype none
`include "dfac_params.svh"
module dfac_bench;
    logic clk_i;
    logic reset_i;
    logic [3:0] addr_i;
    logic [15:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [15:0] rdata_o;
    logic [15:0] flash_rdata_i;
    dfac_pkg::dfac_flash_req_t flash_req_o;
    logic [3:0] rom_pe_entry_o;
    logic data_flash_pe_entry_o;
    logic rom_fetch_allow_o;
    logic pe_busy_o;
    logic access_error_o;
    int mismatches;
    int tests_run;
    int n;

    dfac_top dut (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .flash_rdata_i(flash_rdata_i),
        .flash_req_o(flash_req_o),
        .rom_pe_entry_o(rom_pe_entry_o),
        .data_flash_pe_entry_o(data_flash_pe_entry_o),
        .rom_fetch_allow_o(rom_fetch_allow_o),
        .pe_busy_o(pe_busy_o),
        .access_error_o(access_error_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic finish_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write strobe; returns just after the sampling edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(what, exp, rdata_o);
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask

    initial begin
        mismatches = 0;
        tests_run = 0;
        reset_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        flash_rdata_i = 16'hbeef;
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        check("fetch_allow_rst", 16'h0001, {15'h0, rom_fetch_allow_o});
        rd(`DFAC_OFS_READ_EN0, 16'h0000, "read_en0_rst");
        rd(`DFAC_OFS_MODE_ENTRY, 16'h0000, "entry_rst");
        // wrong key must leave the enables untouched
        wr(`DFAC_OFS_READ_EN0, 16'h5502);
        rd(`DFAC_OFS_READ_EN0, 16'h0000, "read_en0_badkey");
        wr(`DFAC_OFS_READ_EN0, 16'h2d02);
        rd(`DFAC_OFS_READ_EN0, 16'h0002, "read_en0");
        // reserved bits of the blank check register read back as zero
        wr(`DFAC_OFS_BLANK_CHECK, 16'hffff);
        rd(`DFAC_OFS_BLANK_CHECK, 16'h87ff, "blank_check");
        // read of group one finishes within the fixed read latency
        wr(`DFAC_OFS_RD_ADDR, 16'h0800);
        idle(3);
        rd(`DFAC_OFS_RD_DATA, 16'hbeef, "flash_read");
        // each code rom region entered alone, then cleared
        for (int i = 0; i < 4; i++) begin
            wr(`DFAC_OFS_MODE_ENTRY, 16'haa00 | (16'h0001 << i));
            idle(1);
            check("rom_entry", 16'h0001 << i, {12'h0, rom_pe_entry_o});
            check("fetch_in_rom_pe", 16'h0000, {15'h0, rom_fetch_allow_o});
            wr(`DFAC_OFS_MODE_ENTRY, 16'haa00);
        end
        wr(`DFAC_OFS_MODE_ENTRY, 16'haa81);
        wr(`DFAC_OFS_MODE_ENTRY, 16'h5580);
        idle(1);
        check("entry_refused", 16'h0000,
            {11'h0, data_flash_pe_entry_o, rom_pe_entry_o});
        wr(`DFAC_OFS_MODE_ENTRY, 16'haa80);
        idle(1);
        check("df_entry", 16'h0001, {15'h0, data_flash_pe_entry_o});
        rd(`DFAC_OFS_MODE_ENTRY, 16'h0080, "entry_readback");
        wr(`DFAC_OFS_PE_EN0, 16'h2d02);
        // program before the clock is notified is turned away
        wr(`DFAC_OFS_RD_ADDR, 16'h0803);
        idle(4);
        wr(`DFAC_OFS_RD_DATA, 16'h1234);
        wr(`DFAC_OFS_CMD, 16'h0001);
        idle(2);
        check("err_no_clock", 16'h0001, {15'h0, access_error_o});
        wr(`DFAC_OFS_STATUS, 16'h0000);
        idle(2);
        check("err_cleared", 16'h0000, {15'h0, access_error_o});
        wr(`DFAC_OFS_CLK_NOTIFY, 16'h0032);
        rd(`DFAC_OFS_CLK_NOTIFY, 16'h0032, "clk_notify");
        wr(`DFAC_OFS_CMD, 16'h0001);
        check("go", 16'h0001, {15'h0, flash_req_o.go});
        check("is_write", 16'h0001, {15'h0, flash_req_o.is_write});
        check("prog_addr", 16'h0802, {1'b0, flash_req_o.addr});
        check("prog_data", 16'h1234, flash_req_o.wdata);
        idle(1);
        check("go_pulse", 16'h0000, {15'h0, flash_req_o.go});
        check("busy", 16'h0001, {15'h0, pe_busy_o});
        check("fetch_during_pe", 16'h0001, {15'h0, rom_fetch_allow_o});
        // the busy wait is bounded so a stuck engine cannot hang the run
        n = 0;
        while (pe_busy_o !== 1'b0 && n < 100) begin
            idle(1);
            n++;
        end
        if (n >= 100) begin
            mismatches++;
            $display("mismatch pe_busy expected 0 seen %b", pe_busy_o);
            finish_test();
        end
        check("no_err", 16'h0000, {15'h0, access_error_o});
        // group two: read refused, its error beats a clear in the same cycle
        wr(`DFAC_OFS_RD_ADDR, 16'h1000);
        idle(1);
        wr(`DFAC_OFS_STATUS, 16'h0000);
        check("err_read_gate", 16'h0001, {15'h0, access_error_o});
        rd(`DFAC_OFS_RD_DATA, 16'h0000, "read_gated");
        wr(`DFAC_OFS_STATUS, 16'h0000);
        // group two is not enabled for program
        wr(`DFAC_OFS_CMD, 16'h0001);
        idle(2);
        check("err_group", 16'h0001, {15'h0, access_error_o});
        check("no_go", 16'h0000, {15'h0, flash_req_o.go});
        wr(`DFAC_OFS_STATUS, 16'h0000);
        wr(`DFAC_OFS_MODE_ENTRY, 16'haa00);
        idle(1);
        check("df_exit", 16'h0000, {15'h0, data_flash_pe_entry_o});
        finish_test();
    end
endmodule
`default_nettype wire
